// *** ds_router_pkg.sv ***
// Function
// R1 - every location and register is one 16-bit word; data path carries 16 bits
// R2 - addresses 0x0000 to 0x07ff decode to the special function region
// R3 - ram starts at 0x0800, x block then y block, boundary per variant
// R4 - all writes see x and y as one linear space
// R5 - general reads see one combined range; any working register may point
// R6 - dual-operand reads fetch x and y over separate paths together
// R7 - y reads of dual-operand instructions accept only the two y pointers
// R8 - x reads of dual-operand instructions accept only the two x pointers
// R9 - x pointer into y space returns zeros
// R10 - x pointer to unimplemented address raises address error trap
// R11 - y pointer into implemented x space returns zeros
// R12 - y pointer to unimplemented address raises address error trap
// R13 - accumulator write-back uses the write-back pointer into combined space
// R14 - dual-operand writes decode against the whole combined space
// R15 - direct file register access uses 13-bit field, reaching 0x0000 to 0x1fff
// R16 - move instruction addresses the full 64k space directly
// R17 - dual-port ram is read and written by core and dma without stalls
// R18 - upper half of data map can window onto program memory
// R19 - a zero-returning wrong-space read raises no address error trap
// R20 - x/y boundary, ram top and dual-port presence are parameters
package ds_router_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    localparam logic [15:0] SPEC_BASE = 16'h0000;
    localparam logic [15:0] SPEC_LAST = 16'h07ff;
    localparam logic [15:0] RAM_BASE = 16'h0800;
    localparam logic [15:0] NEAR_LAST = 16'h1fff;
    localparam logic [15:0] WINDOW_BASE = 16'h8000;
    localparam int NEAR_W = 13;
    localparam logic [15:0] DATA_RST = 16'h0000;

    // pointer register numbers
    localparam logic [3:0] X_READ_POINTER_A = 4'h8;
    localparam logic [3:0] X_READ_POINTER_B = 4'h9;
    localparam logic [3:0] Y_READ_POINTER_A = 4'ha;
    localparam logic [3:0] Y_READ_POINTER_B = 4'hb;
    localparam logic [3:0] WRITEBACK_POINTER = 4'hd;

    typedef enum logic [1:0] {
        MODE_INDIRECT = 2'h0,
        MODE_NEAR = 2'h1,
        MODE_MOVE = 2'h2,
        MODE_WRITEBACK = 2'h3
    } addr_mode_t;

    typedef enum logic [2:0] {
        TGT_NONE = 3'h0,
        TGT_SPEC = 3'h1,
        TGT_RAM = 3'h3,
        TGT_DPRAM = 3'h2,
        TGT_WINDOW = 3'h6
    } target_t;

    typedef struct packed {
        logic valid;
        logic write;
        addr_mode_t mode;
        logic [3:0] ptr_sel;
        logic [15:0] ptr_addr;
        logic [12:0] near_field;
        logic [15:0] wdata;
    } core_req_t;

    typedef struct packed {
        logic valid;
        logic [3:0] ptr_sel;
        logic [15:0] addr;
    } dual_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } rd_rsp_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dma_req_t;
endpackage : ds_router_pkg

// *** ds_router.sv ***
`timescale 1ns/10ps
module dual_data_space_address_router
    import ds_router_pkg::*;
#(
    parameter logic [15:0] XY_BOUNDARY = 16'h2800,
    parameter logic [15:0] RAM_TOP = 16'h47ff,
    parameter bit HAS_DPRAM = 1'b1,
    parameter logic [15:0] DPRAM_BASE = 16'h4000,
    parameter int RAM_WORDS = 8192
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire core_req_t core_req,
    output rd_rsp_t core_rsp,
    input wire dual_req_t x_req,
    input wire dual_req_t y_req,
    output rd_rsp_t x_rsp,
    output rd_rsp_t y_rsp,
    input wire dma_req_t dma_req,
    output rd_rsp_t dma_rsp,
    input wire logic window_enable,
    input wire logic [7:0] window_page,
    output logic [22:0] prog_addr,
    output logic prog_rd,
    input wire logic [15:0] prog_rdata,
    output logic [15:0] spec_addr,
    output logic spec_rd,
    output logic spec_wr,
    output logic [15:0] spec_wdata,
    input wire logic [15:0] spec_rdata,
    output logic addr_error_trap
);

    ////////////////////////////////////////////////////////////////////////////
    // R20
    initial begin
        if (XY_BOUNDARY <= RAM_BASE || XY_BOUNDARY > RAM_TOP || RAM_TOP >= WINDOW_BASE)
            $error("bad x/y boundary or ram top");
        if (RAM_WORDS < 32'((RAM_TOP - RAM_BASE + 16'h0001) >> 1))
            $error("ram storage too small");
        if (HAS_DPRAM && (DPRAM_BASE < XY_BOUNDARY || DPRAM_BASE > RAM_TOP))
            $error("dual-port base outside y ram");
    end

    localparam int IDX_W = $clog2(RAM_WORDS);

    typedef struct packed {
        rd_rsp_t core_rsp;
        rd_rsp_t x_rsp;
        rd_rsp_t y_rsp;
        rd_rsp_t dma_rsp;
        logic trap;
    } state_t;

    state_t st_reg;
    state_t st_next;
    logic [15:0] ram_q [RAM_WORDS];

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic is_spec(input logic [15:0] a);
        return a <= SPEC_LAST; // R2
    endfunction : is_spec

    function automatic logic in_x(input logic [15:0] a);
        return a >= RAM_BASE && a < XY_BOUNDARY; // R3
    endfunction : in_x

    function automatic logic in_y(input logic [15:0] a);
        return a >= XY_BOUNDARY && a <= RAM_TOP; // R3
    endfunction : in_y

    function automatic logic in_dp(input logic [15:0] a);
        return HAS_DPRAM && a >= DPRAM_BASE && a <= RAM_TOP; // R17
    endfunction : in_dp

    function automatic logic [IDX_W-1:0] ram_idx(input logic [15:0] a);
        logic [15:0] off;
        off = a - RAM_BASE;
        return IDX_W'(off[15:1]); // R1
    endfunction : ram_idx

    ////////////////////////////////////////////////////////////////////////////
    // effective address of the combined-space port
    logic [15:0] core_addr;
    logic core_spec;
    logic core_ram;
    logic core_win;
    logic core_bad;
    logic mode_ok;

    always_comb begin
        unique case (core_req.mode)
            MODE_NEAR: core_addr = {3'h0, core_req.near_field}; // R15
            MODE_MOVE: core_addr = core_req.ptr_addr; // R16
            MODE_WRITEBACK: core_addr = core_req.ptr_addr; // R13
            MODE_INDIRECT: core_addr = core_req.ptr_addr; // R5
        endcase
        mode_ok = core_req.mode != MODE_WRITEBACK ||
            (core_req.ptr_sel == WRITEBACK_POINTER && core_req.write); // R13
        core_spec = is_spec(core_addr); // R2
        core_ram = in_x(core_addr) || in_y(core_addr); // R4 R5 R14
        core_win = window_enable && core_addr >= WINDOW_BASE && !core_req.write; // R18
        core_bad = core_req.valid && (!mode_ok || !(core_spec || core_ram || core_win));
    end

    ////////////////////////////////////////////////////////////////////////////
    // dual-operand x and y decode
    logic x_ptr_ok;
    logic y_ptr_ok;
    logic x_zero;
    logic y_zero;
    logic x_bad;
    logic y_bad;

    always_comb begin
        x_ptr_ok = x_req.ptr_sel == X_READ_POINTER_A || x_req.ptr_sel == X_READ_POINTER_B; // R8
        y_ptr_ok = y_req.ptr_sel == Y_READ_POINTER_A || y_req.ptr_sel == Y_READ_POINTER_B; // R7
        x_zero = in_y(x_req.addr); // R9
        y_zero = in_x(y_req.addr); // R11
        x_bad = x_req.valid && (!x_ptr_ok || !(in_x(x_req.addr) || x_zero)); // R10 R19
        y_bad = y_req.valid && (!y_ptr_ok || !(in_y(y_req.addr) || y_zero)); // R12 R19
    end

    // dma reaches only the dual-port region; core never waits for it
    logic dma_hit;
    assign dma_hit = dma_req.valid && in_dp(dma_req.addr); // R17

    ////////////////////////////////////////////////////////////////////////////
    // side ports toward registers and program memory
    always_comb begin
        spec_addr = core_addr;
        spec_rd = core_req.valid && !core_req.write && core_spec;
        spec_wr = core_req.valid && core_req.write && core_spec && mode_ok;
        spec_wdata = core_req.wdata;
        prog_rd = core_req.valid && core_win && !core_spec && !core_ram; // R18
        prog_addr = {window_page, core_addr[14:0]}; // R18
    end

    ////////////////////////////////////////////////////////////////////////////
    // responses: one cycle after the request
    always_comb begin
        st_next = st_reg;
        st_next.core_rsp.valid = core_req.valid && !core_req.write;
        st_next.core_rsp.data = DATA_RST;
        if (core_req.valid && !core_req.write && !core_bad) begin
            if (core_spec)
                st_next.core_rsp.data = spec_rdata;
            else if (core_ram)
                st_next.core_rsp.data = ram_q[ram_idx(core_addr)]; // R5
            else
                st_next.core_rsp.data = prog_rdata; // R18
        end
        st_next.x_rsp.valid = x_req.valid; // R6
        st_next.x_rsp.data = (x_req.valid && !x_bad && !x_zero) ?
            ram_q[ram_idx(x_req.addr)] : DATA_RST; // R9
        st_next.y_rsp.valid = y_req.valid; // R6
        st_next.y_rsp.data = (y_req.valid && !y_bad && !y_zero) ?
            ram_q[ram_idx(y_req.addr)] : DATA_RST; // R11
        st_next.dma_rsp.valid = dma_req.valid && !dma_req.write;
        st_next.dma_rsp.data = (dma_hit && !dma_req.write) ?
            ram_q[ram_idx(dma_req.addr)] : DATA_RST; // R17
        st_next.trap = core_bad || x_bad || y_bad; // R10 R12
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ram storage; core write wins over a dma write to the same word
    logic core_wr_ram;
    logic dma_wr_ram;
    assign core_wr_ram = core_req.valid && core_req.write && core_ram && mode_ok; // R4 R14
    assign dma_wr_ram = dma_hit && dma_req.write && !(core_wr_ram &&
        ram_idx(dma_req.addr) == ram_idx(core_addr)); // R17

    for (genvar i = 0; i < RAM_WORDS; i++) begin : g_ram
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                ram_q[i] <= DATA_RST;
            end else if (core_wr_ram && ram_idx(core_addr) == IDX_W'(i)) begin
                ram_q[i] <= core_req.wdata; // R1
            end else if (dma_wr_ram && ram_idx(dma_req.addr) == IDX_W'(i)) begin
                ram_q[i] <= dma_req.wdata;
            end
        end
    end

    assign core_rsp = st_reg.core_rsp;
    assign x_rsp = st_reg.x_rsp;
    assign y_rsp = st_reg.y_rsp;
    assign dma_rsp = st_reg.dma_rsp;
    assign addr_error_trap = st_reg.trap;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_x_wrong_space;
        x_req.valid && x_ptr_ok && in_y(x_req.addr);
    endsequence

    sequence s_y_wrong_space;
        y_req.valid && y_ptr_ok && in_x(y_req.addr);
    endsequence

    AST_X_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n) // R9
        s_x_wrong_space |=> x_rsp.valid && x_rsp.data == 16'h0000)
        else $error("x pointer in y space did not read zero");
    AST_Y_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n) // R11
        s_y_wrong_space |=> y_rsp.valid && y_rsp.data == 16'h0000)
        else $error("y pointer in x space did not read zero");
    AST_NO_TRAP_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n) // R19
        s_x_wrong_space and s_y_wrong_space and !core_req.valid |=> !addr_error_trap)
        else $error("wrong-space read trapped");
    AST_X_UNIMPL: assert property (@(posedge clk_sys) disable iff (!arst_n) // R10
        x_req.valid && x_ptr_ok && x_req.addr > RAM_TOP |=> addr_error_trap)
        else $error("x unimplemented address no trap");
    AST_Y_UNIMPL: assert property (@(posedge clk_sys) disable iff (!arst_n) // R12
        y_req.valid && y_ptr_ok && y_req.addr > RAM_TOP |=> addr_error_trap)
        else $error("y unimplemented address no trap");
    AST_X_PTR: assert property (@(posedge clk_sys) disable iff (!arst_n) // R8
        x_req.valid && !x_ptr_ok |=> addr_error_trap && x_rsp.data == 16'h0000)
        else $error("foreign x pointer accepted");
    AST_Y_PTR: assert property (@(posedge clk_sys) disable iff (!arst_n) // R7
        y_req.valid && !y_ptr_ok |=> addr_error_trap && y_rsp.data == 16'h0000)
        else $error("foreign y pointer accepted");
    AST_SFR: assert property (@(posedge clk_sys) disable iff (!arst_n) // R2
        core_req.valid && !core_req.write && core_req.mode == MODE_MOVE &&
        core_req.ptr_addr <= SPEC_LAST |-> spec_rd && !prog_rd)
        else $error("register region address not routed to its port");
    AST_NEAR: assert property (@(posedge clk_sys) disable iff (!arst_n) // R15
        core_req.mode == MODE_NEAR |-> core_addr <= NEAR_LAST)
        else $error("near address out of range");
    AST_WRITE_ROUND: assert property (@(posedge clk_sys) disable iff (!arst_n) // R4
        core_req.valid && core_req.write && core_req.mode == MODE_MOVE &&
        in_y(core_req.ptr_addr) && !dma_req.valid ##1 core_req.valid && !core_req.write &&
        core_req.mode == MODE_MOVE && core_req.ptr_addr == $past(core_req.ptr_addr)
        |=> core_rsp.data == $past(core_req.wdata, 2))
        else $error("combined-space write not read back");
    AST_WINDOW: assert property (@(posedge clk_sys) disable iff (!arst_n) // R18
        prog_rd && !core_bad |=> core_rsp.data == $past(prog_rdata))
        else $error("window read did not return program data");

    sequence s_core_read;
        core_req.valid && !core_req.write;
    endsequence

    sequence s_core_write;
        core_req.valid && core_req.write;
    endsequence

    sequence s_no_request;
        !core_req.valid && !x_req.valid && !y_req.valid;
    endsequence

    AST_RSP_ONE: assert property (@(posedge clk_sys) disable iff (!arst_n) // R5
        s_core_read |=> core_rsp.valid)
        else $error("core read gave no response");
    AST_RSP_NONE: assert property (@(posedge clk_sys) disable iff (!arst_n) // R5
        !(core_req.valid && !core_req.write) |=> !core_rsp.valid)
        else $error("core response without a read");
    AST_XY_BOTH: assert property (@(posedge clk_sys) disable iff (!arst_n) // R6
        x_req.valid && y_req.valid |=> x_rsp.valid && y_rsp.valid)
        else $error("dual read did not answer both spaces together");
    AST_WB_PTR: assert property (@(posedge clk_sys) disable iff (!arst_n) // R13
        core_req.valid && core_req.mode == MODE_WRITEBACK &&
        core_req.ptr_sel != WRITEBACK_POINTER |-> !core_wr_ram && !spec_wr ##1 addr_error_trap)
        else $error("write-back through a foreign pointer accepted");
    AST_WIN_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n) // R18
        s_core_write && core_addr >= WINDOW_BASE |-> !prog_rd ##1 addr_error_trap)
        else $error("write into the program window accepted");
    AST_DMA_OUTSIDE: assert property (@(posedge clk_sys) disable iff (!arst_n) // R17
        dma_req.valid && !dma_req.write && !in_dp(dma_req.addr)
        |=> dma_rsp.valid && dma_rsp.data == 16'h0000)
        else $error("dma read outside dual-port region not zero");
    AST_DMA_NO_TRAP: assert property (@(posedge clk_sys) disable iff (!arst_n) // R17
        s_no_request |=> !addr_error_trap)
        else $error("trap raised without an offending request");
    AST_SPEC_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n) // R2
        s_core_write && core_req.mode == MODE_MOVE && core_req.ptr_addr <= SPEC_LAST
        |-> spec_wr && spec_wdata == core_req.wdata && !core_wr_ram)
        else $error("register region write not routed to its port");
    AST_RAM_NOT_SPEC: assert property (@(posedge clk_sys) disable iff (!arst_n) // R3
        core_req.valid && core_req.mode == MODE_MOVE &&
        core_req.ptr_addr >= RAM_BASE |-> !spec_rd && !spec_wr)
        else $error("ram address reached the register region port");
    AST_RAM_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n) // R14
        s_core_write && core_req.mode == MODE_INDIRECT &&
        core_req.ptr_addr >= RAM_BASE && core_req.ptr_addr <= RAM_TOP |-> core_wr_ram)
        else $error("write in combined space not stored");

endmodule : dual_data_space_address_router

// *** datapath_side_model.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// register bank and program memory behind the router, answering in the same cycle
module datapath_side_model (
    input wire logic [15:0] spec_addr,
    input wire logic spec_rd,
    output logic [15:0] spec_rdata,
    input wire logic [22:0] prog_addr,
    input wire logic prog_rd,
    output logic [15:0] prog_rdata
);
    // unselected: spec data is the inverse of its pattern, prog data the inverted address, so a stale value never matches
    assign spec_rdata = spec_rd ? (spec_addr ^ 16'h3c3c) : ~(spec_addr ^ 16'h3c3c);
    assign prog_rdata = prog_rd ? (prog_addr[15:0] ^ 16'hc3c3) : ~prog_addr[15:0];
endmodule : datapath_side_model

// *** dual_data_space_address_router_tb.sv ***
`timescale 1ns/10ps
module dual_data_space_address_router_tb;
    import ds_router_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    core_req_t creq = '0;
    dual_req_t xq = '0;
    dual_req_t yq = '0;
    dma_req_t dq = '0;
    logic win_en = 1'b0;
    logic [7:0] win_page = 8'h00;
    rd_rsp_t core_rsp, x_rsp, y_rsp, dma_rsp;
    logic [22:0] prog_addr;
    logic prog_rd, spec_rd, spec_wr, trap, trap_seen, spec_seen, spec_wr_seen;
    logic [15:0] prog_rdata, spec_addr, spec_wdata, spec_rdata, wdata_seen;
    int n_mismatch = 0;
    int checked = 0;
    ////////////////////////////////////////////////////////////////////////////
    dual_data_space_address_router #(.XY_BOUNDARY(16'h0c00), .RAM_TOP(16'h0fff),
        .HAS_DPRAM(1'b1), .DPRAM_BASE(16'h0e00), .RAM_WORDS(1024)
    ) u_dual_data_space_address_router (.clk_sys(clk_sys), .arst_n(arst_n),
        .core_req(creq), .core_rsp(core_rsp), .x_req(xq), .y_req(yq), .x_rsp(x_rsp),
        .y_rsp(y_rsp), .dma_req(dq), .dma_rsp(dma_rsp), .window_enable(win_en),
        .window_page(win_page), .prog_addr(prog_addr), .prog_rd(prog_rd),
        .prog_rdata(prog_rdata), .spec_addr(spec_addr), .spec_rd(spec_rd), .spec_wr(spec_wr),
        .spec_wdata(spec_wdata), .spec_rdata(spec_rdata), .addr_error_trap(trap));
    datapath_side_model u_datapath_side_model (.spec_addr(spec_addr), .spec_rd(spec_rd),
        .spec_rdata(spec_rdata), .prog_addr(prog_addr), .prog_rd(prog_rd),
        .prog_rdata(prog_rdata));
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (n_mismatch == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wait_rsp();
        int i;
        for (i = 0; i < 4; i++) begin
            #1;
            if ({core_rsp.valid, x_rsp.valid, y_rsp.valid, dma_rsp.valid, trap} !== 5'h00) break;
            @(posedge clk_sys);
        end
        trap_seen = trap;
        if (i == 4) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : wait_rsp
    task automatic core_op(logic w, addr_mode_t m, logic [3:0] sel, logic [15:0] a,
                           logic [15:0] d);
        @(posedge clk_sys);
        creq <= '{1'b1, w, m, sel, a, a[12:0], d};
        #1 spec_seen = spec_rd;
        spec_wr_seen = spec_wr;
        wdata_seen = spec_wdata;
        @(posedge clk_sys);
        creq.valid <= 1'b0;
    endtask : core_op
    task automatic dual_op(logic [3:0] xs, logic [15:0] xa, logic xv, logic [3:0] ys,
                           logic [15:0] ya, logic yv);
        @(posedge clk_sys);
        xq <= '{xv, xs, xa};
        yq <= '{yv, ys, ya};
        @(posedge clk_sys);
        xq.valid <= 1'b0;
        yq.valid <= 1'b0;
        wait_rsp();
    endtask : dual_op
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_combined();
        core_op(1'b1, MODE_INDIRECT, 4'h2, 16'h0900, 16'ha5c3);
        core_op(1'b1, MODE_MOVE, 4'h0, 16'h0c10, 16'h5a3c);
        core_op(1'b0, MODE_INDIRECT, 4'h3, 16'h0900, 16'h0000);
        wait_rsp();
        chk("core_x", 16'ha5c3, core_rsp.data);
        core_op(1'b0, MODE_MOVE, 4'h5, 16'h0c10, 16'h0000);
        wait_rsp();
        chk("core_y", 16'h5a3c, core_rsp.data);
    endtask : t_combined
    task automatic t_dual();
        dual_op(X_READ_POINTER_A, 16'h0900, 1'b1, Y_READ_POINTER_A, 16'h0c10, 1'b1);
        chk("x_rd", 16'ha5c3, x_rsp.data);
        chk("y_rd", 16'h5a3c, y_rsp.data);
        dual_op(X_READ_POINTER_B, 16'h0c10, 1'b1, Y_READ_POINTER_B, 16'h0900, 1'b1);
        chk("x_in_y", 16'h0000, x_rsp.data);
        chk("y_in_x", 16'h0000, y_rsp.data);
        chk("wrong_space_trap", 16'h0000, {15'h0, trap_seen});
    endtask : t_dual
    task automatic t_faults();
        dual_op(X_READ_POINTER_A, 16'h1100, 1'b1, Y_READ_POINTER_A, 16'h0c10, 1'b0);
        chk("x_unimp_trap", 16'h0001, {15'h0, trap_seen});
        dual_op(X_READ_POINTER_A, 16'h0900, 1'b0, Y_READ_POINTER_B, 16'h1100, 1'b1);
        chk("y_unimp_trap", 16'h0001, {15'h0, trap_seen});
        dual_op(Y_READ_POINTER_A, 16'h0900, 1'b1, Y_READ_POINTER_A, 16'h0c10, 1'b0);
        chk("x_bad_ptr_trap", 16'h0001, {15'h0, trap_seen});
        chk("x_bad_ptr_data", 16'h0000, x_rsp.data);
        dual_op(X_READ_POINTER_A, 16'h0900, 1'b0, X_READ_POINTER_B, 16'h0c10, 1'b1);
        chk("y_bad_ptr_trap", 16'h0001, {15'h0, trap_seen});
    endtask : t_faults
    task automatic t_writeback();
        core_op(1'b1, MODE_WRITEBACK, WRITEBACK_POINTER, 16'h0c20, 16'h1234);
        dual_op(X_READ_POINTER_A, 16'h0900, 1'b0, Y_READ_POINTER_B, 16'h0c20, 1'b1);
        chk("wb_data", 16'h1234, y_rsp.data);
        core_op(1'b1, MODE_WRITEBACK, 4'hc, 16'h0c22, 16'hffff);
        wait_rsp();
        chk("wb_bad_ptr_trap", 16'h0001, {15'h0, trap_seen});
        core_op(1'b0, MODE_INDIRECT, 4'h1, 16'h0c22, 16'h0000);
        wait_rsp();
        chk("wb_not_written", 16'h0000, core_rsp.data);
    endtask : t_writeback
    task automatic t_direct();
        // pointer value is unimplemented, only the 13-bit field may be used
        core_op(1'b0, MODE_NEAR, 4'h0, 16'h2900, 16'h0000);
        wait_rsp();
        chk("near_rd", 16'ha5c3, core_rsp.data);
        core_op(1'b0, MODE_INDIRECT, 4'h4, 16'h0010, 16'h0000);
        chk("spec_sel", 16'h0001, {15'h0, spec_seen});
        wait_rsp();
        chk("spec_rd", 16'h3c2c, core_rsp.data);
        core_op(1'b1, MODE_MOVE, 4'h4, 16'h0020, 16'h7e81);
        chk("spec_wr", 16'h0001, {15'h0, spec_wr_seen});
        chk("spec_wdata", 16'h7e81, wdata_seen);
        @(posedge clk_sys);
        win_en <= 1'b1;
        win_page <= 8'h03;
        core_op(1'b0, MODE_MOVE, 4'h6, 16'h8004, 16'h0000);
        wait_rsp();
        chk("window_rd", 16'h43c7, core_rsp.data);
        core_op(1'b1, MODE_MOVE, 4'h6, 16'h8004, 16'h1111);
        wait_rsp();
        chk("window_wr_trap", 16'h0001, {15'h0, trap_seen});
    endtask : t_direct
    task automatic t_dma();
        @(posedge clk_sys);
        dq <= '{1'b1, 1'b1, 16'h0e04, 16'hbeef};
        @(posedge clk_sys);
        dq <= '{1'b1, 1'b0, 16'h0e04, 16'h0000};
        creq <= '{1'b1, 1'b0, MODE_INDIRECT, 4'h7, 16'h0e04, 13'h0000, 16'h0000};
        @(posedge clk_sys);
        dq.valid <= 1'b0;
        creq.valid <= 1'b0;
        wait_rsp();
        chk("dma_rd", 16'hbeef, dma_rsp.data);
        chk("core_dp_rd", 16'hbeef, core_rsp.data);
    endtask : t_dma
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_combined();
        t_dual();
        t_faults();
        t_writeback();
        t_direct();
        t_dma();
        report_and_stop();
    end
endmodule : dual_data_space_address_router_tb
